// file: adc_front_pkg.sv
package adc_front_pkg;

	localparam int num_ports      = 4;
	localparam int num_channels   = 6;
	localparam int mant_width     = 16;
	localparam int exp_width      = 3;
	localparam int sel_width      = 3;
	localparam int pn_width       = 16;

	// crossbar select codes
	localparam logic [2:0] sel_port_a = 3'h0;
	localparam logic [2:0] sel_port_b = 3'h1;
	localparam logic [2:0] sel_port_c = 3'h2;
	localparam logic [2:0] sel_port_d = 3'h3;
	localparam logic [2:0] sel_pn     = 3'h4;

	// bit positions of the complex pairing controls in the input control word
	localparam int cplx_ab_bit = 24;
	localparam int cplx_cd_bit = 25;

	localparam logic [15:0] pn_seed        = 16'hace1;
	localparam logic [15:0] pn_taps        = 16'hb400;
	localparam logic [15:0] mant_reset     = 16'h0000;
	localparam logic [2:0]  exp_reset      = 3'h0;

	typedef struct packed {
		logic [15:0] mantissa;
		logic [2:0]  exponent;
	} sample_t;

	typedef struct packed {
		logic [15:0] i_data;
		logic [15:0] q_data;
		logic        complex_valid;
		logic        valid;
	} chan_sample_t;

endpackage

// file: adc_input_port_crossbar.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module adc_input_port_crossbar
	import adc_front_pkg::*;
#(
	parameter int channels = num_channels
) (
	input  wire logic                          mclk,
	input  wire logic                          srst,
	input  wire logic [num_ports-1:0]          port_sample_clock,
	input  wire logic [num_ports-1:0][15:0]    port_mantissa,
	input  wire logic [num_ports-1:0][2:0]     port_exp_in,
	output logic      [num_ports-1:0][2:0]     port_exp_out,
	output logic      [num_ports-1:0][2:0]     port_exp_oe_n,
	input  wire logic [num_ports-1:0]          clock_invert,
	input  wire logic [num_ports-1:0]          exp_as_gain_out,
	input  wire logic [num_ports-1:0][2:0]     gain_range_word,
	input  wire logic [31:0]                   input_control,
	input  wire logic [channels-1:0][2:0]      channel_select,
	input  wire logic [channels-1:0]           channel_complex,
	output chan_sample_t [channels-1:0]        channel_out,
	output logic                               pll_reference_clock
);

	//////////////////////////////////////////////////////////////////////////
	// elaboration checks: the datapath is cut for these sizes only
	if (channels < 1 || channels > 16) begin : g_bad_channels
		$error("channels out of range");
	end
	if (num_ports != 4) begin : g_bad_ports
		$error("crossbar decodes exactly four ports");
	end
	if (mant_width != 16 || exp_width != 3) begin : g_bad_sample
		$error("sample word must be 16 plus 3 bits");
	end
	if (sel_width != 3) begin : g_bad_select
		$error("select word must be 3 bits");
	end

	//////////////////////////////////////////////////////////////////////////
	// port sampling: two flops per pin, then edge detect on the clock level
	logic [num_ports-1:0] clk_s1_reg;
	logic [num_ports-1:0] clk_s2_reg;
	logic [num_ports-1:0] clk_s3_reg;
	sample_t              pin_s1_reg [num_ports];
	sample_t              pin_s2_reg [num_ports];
	sample_t              cap_reg [num_ports];
	logic                 cap_strobe_reg [num_ports];
	logic [15:0]          scaled_reg [num_ports];
	logic                 scaled_strobe_reg [num_ports];

	// no reset: a forced low level would fake an edge when the pin sits high
	always_ff @(posedge mclk) begin
		clk_s1_reg <= port_sample_clock;
		clk_s2_reg <= clk_s1_reg;
		clk_s3_reg <= clk_s2_reg;
	end

	// port a clock level passed on as the multiplier reference
	assign pll_reference_clock = clk_s2_reg[0];

	// exponent pins turn round as a group
	assign port_exp_out = gain_range_word;

	always_comb begin
		for (int k = 0; k < num_ports; k++) begin
			port_exp_oe_n[k] = exp_as_gain_out[k] ? 3'h0 : 3'h7;
		end
	end

	genvar p;
	generate
		for (p = 0; p < num_ports; p++) begin : g_port
			logic       edge_hit;
			logic [2:0] exp_eff;
			// edge picked per port, independent of the others
			assign edge_hit = clock_invert[p] ? (clk_s3_reg[p] & ~clk_s2_reg[p])
				: (~clk_s3_reg[p] & clk_s2_reg[p]);
			// pins driven as gain outputs carry no exponent; read as zero
			assign exp_eff = exp_as_gain_out[p] ? exp_reset : cap_reg[p].exponent;

			always_ff @(posedge mclk) begin
				if (srst) begin
					pin_s1_reg[p] <= '{mant_reset, exp_reset};
					pin_s2_reg[p] <= '{mant_reset, exp_reset};
				end else begin
					pin_s1_reg[p] <= '{port_mantissa[p], port_exp_in[p]};
					pin_s2_reg[p] <= pin_s1_reg[p];
				end
			end

			// mantissa and exponent taken on one strobe so they never skew
			always_ff @(posedge mclk) begin
				if (srst) begin
					cap_reg[p] <= '{mant_reset, exp_reset};
				end else if (edge_hit) begin
					cap_reg[p] <= pin_s2_reg[p];
				end
			end

			always_ff @(posedge mclk) begin
				if (srst) begin
					cap_strobe_reg[p] <= 1'b0;
				end else begin
					cap_strobe_reg[p] <= edge_hit;
				end
			end

			// signed shift; sign bit fills from the left
			always_ff @(posedge mclk) begin
				if (srst) begin
					scaled_reg[p] <= mant_reset;
				end else begin
					scaled_reg[p] <= 16'($signed(cap_reg[p].mantissa) >>> exp_eff);
				end
			end

			// strobe delayed one stage so valid marks the new scaled value
			always_ff @(posedge mclk) begin
				if (srst) begin
					scaled_strobe_reg[p] <= 1'b0;
				end else begin
					scaled_strobe_reg[p] <= cap_strobe_reg[p];
				end
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// pseudorandom test source, galois lfsr on the processing clock
	logic [15:0] pn_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			pn_reg <= pn_seed;
		end else begin
			pn_reg <= pn_reg[0] ? ((pn_reg >> 1) ^ pn_taps) : (pn_reg >> 1);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// crossbar; one sample stream per port is assumed
	logic        cplx_ab;
	logic        cplx_cd;
	logic [15:0] i_data_reg [channels];
	logic [15:0] q_data_reg [channels];
	logic        valid_reg [channels];
	logic        paired_reg [channels];

	assign cplx_ab = input_control[cplx_ab_bit];
	assign cplx_cd = input_control[cplx_cd_bit];

	genvar c;
	generate
		for (c = 0; c < channels; c++) begin : g_chan
			logic [1:0] port_idx;
			logic       pair_ab;
			logic       pair_cd;
			assign port_idx = channel_select[c][1:0];
			// complex pairs only when both the pair and the channel ask for it
			assign pair_ab = channel_complex[c] && channel_select[c] == sel_port_a && cplx_ab;
			assign pair_cd = channel_complex[c] && channel_select[c] == sel_port_c && cplx_cd;

			// real part, or the only part of a real channel
			always_ff @(posedge mclk) begin
				if (srst) begin
					i_data_reg[c] <= mant_reset;
				end else begin
					case (channel_select[c])
						sel_port_a, sel_port_b, sel_port_c, sel_port_d: begin
							i_data_reg[c] <= scaled_reg[port_idx];
						end
						sel_pn: begin
							i_data_reg[c] <= pn_reg;
						end
						default: begin
							i_data_reg[c] <= mant_reset;
						end
					endcase
				end
			end

			// valid follows the same select as the data it marks
			always_ff @(posedge mclk) begin
				if (srst) begin
					valid_reg[c] <= 1'b0;
				end else begin
					case (channel_select[c])
						sel_port_a, sel_port_b, sel_port_c, sel_port_d: begin
							valid_reg[c] <= scaled_strobe_reg[port_idx];
						end
						sel_pn: begin
							valid_reg[c] <= 1'b1;
						end
						default: begin
							valid_reg[c] <= 1'b0;
						end
					endcase
				end
			end

			// imaginary part from the partner port of the pair
			always_ff @(posedge mclk) begin
				if (srst) begin
					q_data_reg[c] <= mant_reset;
					paired_reg[c] <= 1'b0;
				end else if (pair_ab) begin
					q_data_reg[c] <= scaled_reg[1];
					paired_reg[c] <= 1'b1;
				end else if (pair_cd) begin
					q_data_reg[c] <= scaled_reg[3];
					paired_reg[c] <= 1'b1;
				end else begin
					q_data_reg[c] <= mant_reset;
					paired_reg[c] <= 1'b0;
				end
			end
		end
	endgenerate

	// gather the per-channel flops onto the packed output
	always_comb begin
		for (int k = 0; k < channels; k++) begin
			channel_out[k].i_data        = i_data_reg[k];
			channel_out[k].q_data        = q_data_reg[k];
			channel_out[k].complex_valid = paired_reg[k];
			channel_out[k].valid         = valid_reg[k];
		end
	end

endmodule

// file: adc_crossbar_asserts.sv
`timescale 1ns/1ps
module adc_crossbar_asserts
	import adc_front_pkg::*;
#(
	parameter int channels = num_channels
) (
	input wire logic                        mclk,
	input wire logic                        srst,
	input wire logic [num_ports-1:0]        port_sample_clock,
	input wire logic [num_ports-1:0][2:0]   port_exp_out,
	input wire logic [num_ports-1:0][2:0]   port_exp_oe_n,
	input wire logic [num_ports-1:0]        clock_invert,
	input wire logic [num_ports-1:0]        exp_as_gain_out,
	input wire logic [num_ports-1:0][2:0]   gain_range_word,
	input wire logic [31:0]                 input_control,
	input wire logic [channels-1:0][2:0]    channel_select,
	input wire chan_sample_t [channels-1:0] channel_out,
	input wire logic                        pll_reference_clock
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_exp_drive: assert property (port_exp_out == gain_range_word)
		else $error("gain word not on pins");
	a_oe_low: assert property (port_exp_oe_n[0] == {3{!exp_as_gain_out[0]}})
		else $error("pin enable wrong");
	a_pn_valid: assert property ((channel_select[1] == sel_pn) [*3]
		|-> channel_out[1].valid) else $error("test source not valid");
	a_bad_sel: assert property ((channel_select[0] == 3'h7) [*3]
		|-> channel_out[0] == '0) else $error("bad select not zero");
	a_one_pulse: assert property (channel_out[2].valid
		&& channel_select[2] == sel_port_a |=> !channel_out[2].valid)
		else $error("valid too long");
	// two-flop sync plus capture stages, so a pin edge lands within a handful of cycles
	a_rise_cap: assert property ($rose(port_sample_clock[0]) && !clock_invert[0]
		&& channel_select[2] == sel_port_a |-> ##[2:8] channel_out[2].valid)
		else $error("rising edge not captured");
	a_no_pair: assert property ((!input_control[cplx_ab_bit]
		&& !input_control[cplx_cd_bit]) [*2] |-> !channel_out[2].complex_valid)
		else $error("complex without pair bit");
	a_pll_ref: assert property ($rose(port_sample_clock[0])
		|-> ##[1:3] pll_reference_clock) else $error("reference clock late");
endmodule
//////////////////////////////////////////////////////////////////////////////
bind adc_input_port_crossbar adc_crossbar_asserts #(.channels(channels)) chk (.mclk(mclk),
	.srst(srst), .port_sample_clock(port_sample_clock), .port_exp_out(port_exp_out),
	.port_exp_oe_n(port_exp_oe_n), .clock_invert(clock_invert),
	.exp_as_gain_out(exp_as_gain_out), .gain_range_word(gain_range_word),
	.input_control(input_control), .channel_select(channel_select),
	.channel_out(channel_out), .pll_reference_clock(pll_reference_clock));

// file: adc_source.sv
`timescale 1ns/1ps
module adc_source
	import adc_front_pkg::*;
(
	output logic      [num_ports-1:0]       clk,
	output logic      [num_ports-1:0][15:0] mant,
	output logic      [num_ports-1:0][2:0]  expo,
	input  wire logic [num_ports-1:0][15:0] mant_next,
	input  wire logic [num_ports-1:0][2:0]  exp_next
);
	initial {mant, expo} = '0;
	// free running, phase unrelated to mclk
	for (genvar p = 0; p < num_ports; p++) begin : g_clk
		initial begin
			clk[p] = 1'b0;
			#(7 + 13 * p);
			forever #100 clk[p] = ~clk[p];
		end
	end
	// one stream per port; updates mid phase of clk[0], away from both of its edges
	always @(posedge clk[0]) begin
		#50;
		mant <= mant_next;
		expo <= exp_next;
	end
endmodule

// file: tb_adc_input_port_crossbar.sv
`timescale 1ns/1ps
module tb_adc_input_port_crossbar;
	import adc_front_pkg::*;
	logic mclk = 1'b0, srst = 1'b1, pll;
	logic [3:0] inv = '0, gout = '0, pclk;
	logic [3:0][15:0] pm, mn = '0, m4 = {16'hd00d, 16'h0c0c, 16'h7bbb, 16'h8aaa};
	logic [3:0][2:0] pe, en = '0, gw = '0, xo, oe_n, xp;
	logic [31:0] ictl = '0;
	logic [5:0][2:0] sel = '0;
	logic [5:0] cplx = '0;
	chan_sample_t [5:0] co;
	int mismatches = 0, comparisons = 0;
	assign xp = (oe_n & pe) | (~oe_n & xo);
	initial forever #12.5 mclk = ~mclk;
	adc_source src (.clk(pclk), .mant(pm), .expo(pe), .mant_next(mn), .exp_next(en));
	adc_input_port_crossbar dut (.mclk(mclk), .srst(srst), .port_sample_clock(pclk),
		.port_mantissa(pm), .port_exp_in(xp), .port_exp_out(xo), .port_exp_oe_n(oe_n),
		.clock_invert(inv), .exp_as_gain_out(gout), .gain_range_word(gw),
		.input_control(ictl), .channel_select(sel), .channel_complex(cplx),
		.channel_out(co), .pll_reference_clock(pll));
	//////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		comparisons++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value at %0t: got %h, expected %h", $time, seen, want);
		end
	endtask
	// data held for several port clocks, so either edge sees it settled
	task automatic put(input logic [3:0][15:0] m, input logic [3:0][2:0] e);
		mn = m;
		en = e;
		repeat (30) @(negedge mclk);
	endtask
	task automatic give_verdict;
		$display("%0d checks, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#60000;
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (20) @(negedge mclk);
		srst = 1'b0;
		for (int n = 0; n < 8; n++) begin
			put({4{16'h9ab5}}, {4{3'(n)}});
			chk(co[0].i_data, 16'($signed(16'h9ab5) >>> n));
		end
		$display("exponent test done");
		sel = {sel_port_d, sel_port_c, sel_port_b, sel_port_a, sel_pn, 3'h7};
		for (int v = 0; v < 2; v++) begin
			srst = 1'b1;
			inv = {4{v[0]}};
			repeat (2) @(negedge mclk);
			srst = 1'b0;
			put(m4, '0);
			for (int c = 2; c < 6; c++) chk(co[c].i_data, m4[c - 2]);
			chk(co[0].i_data, 16'h0);
			chk(16'(co[1].valid), 16'h1);
		end
		$display("crossbar test done");
		gout = 4'hf;
		gw = {3'h6, 3'h5, 3'h2, 3'h1};
		put(m4, {4{3'h7}});
		chk({4'h0, oe_n}, 16'h0);
		chk({4'h0, xo}, {4'h0, 3'h6, 3'h5, 3'h2, 3'h1});
		chk(co[2].i_data, m4[0]);
		$display("gain pin test done");
		gout = '0;
		ictl[cplx_ab_bit] = 1'b1;
		ictl[cplx_cd_bit] = 1'b1;
		cplx = 6'h14;
		put(m4, '0);
		chk(co[2].q_data, m4[1]);
		chk(co[4].q_data, m4[3]);
		chk(16'(co[2].complex_valid), 16'h1);
		chk(16'(co[3].complex_valid), 16'h0);
		$display("complex test done");
		give_verdict();
	end
endmodule
